/* File: core/emb_bus_seq.sv */
// Function
// - static logic; stopped oscillator freezes all pins and counters
// - any oscillator duty, only phase minimums
// - fetch address valid before latch strobe falls
// - low address held one period after latch
// - high address port stable through whole cycle
// - fetch access window three periods
// - instruction latched before program strobe rises
// - data read access window six periods
// - write data driven before write strobe
// - write data held after write strobe
// - port inputs sampled at state5 phase2
// - port outputs updated after state6 phase2
module emb_bus_seq (
  // clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 sys_rst,
  // oscillator
  input  wire logic                 osc_input,
  // user request
  input  wire logic                 req_valid,
  input  wire emb_pkg::emb_req_s    req,
  output logic                      req_ready,
  // user answer
  output logic                      rsp_valid,
  output logic [7:0]                rsp_data,
  // user side of the general port
  input  wire logic [7:0]           gp_out_data,
  output logic [7:0]                gp_in_data,
  // general port pins
  input  wire logic [7:0]           gp_port_i,
  output logic [7:0]                gp_port_o,
  // external bus pins
  input  wire logic [7:0]           low_addr_data_port_i,
  output logic [7:0]                low_addr_data_port_o,
  output logic                      low_addr_data_port_oe,
  output logic [7:0]                high_addr_port,
  output logic                      ale,
  output logic                      prog_store_strobe_n,
  output logic                      rd_strobe_n,
  output logic                      wr_strobe_n
);

  typedef struct packed {
    emb_pkg::emb_op_e              op;
    logic [emb_pkg::CNT_W-1:0]     cnt;
    logic [15:0]                   addr;
    logic [7:0]                    wdata;
    emb_pkg::emb_pins_s            pins;
    logic [7:0]                    rdata;
    logic                          rsp;
    logic [7:0]                    port_smp;
    logic [7:0]                    port_out;
  } emb_seq_s;

  emb_seq_s st_ff;
  emb_seq_s nxt_st;
  logic     tick;
  logic     at_end;

  emb_osc_tick u_tick (
    .clk_sys   (clk_sys),
    .sys_rst   (sys_rst),
    .osc_input (osc_input),
    .tick      (tick)
  );

  function automatic logic in_win(
    input logic [emb_pkg::CNT_W-1:0] c,
    input logic [emb_pkg::CNT_W-1:0] lo,
    input logic [emb_pkg::CNT_W-1:0] hi
  );
    in_win = (c >= lo) && (c <= hi);
  endfunction

  function automatic logic [emb_pkg::CNT_W-1:0] last_of(input emb_pkg::emb_op_e op);
    case (op)
      emb_pkg::OP_READ,
      emb_pkg::OP_WRITE: last_of = emb_pkg::LONG_LAST;
      default:           last_of = emb_pkg::SHORT_LAST;
    endcase
  endfunction

  // pin levels for a given period of a cycle; registered, so pins change on tick edges
  function automatic emb_pkg::emb_pins_s pins_for(
    input emb_pkg::emb_op_e          op,
    input logic [emb_pkg::CNT_W-1:0] c,
    input logic [15:0]               a,
    input logic [7:0]                wd
  );
    emb_pkg::emb_pins_s p;
    logic               busy;
    p    = emb_pkg::PINS_RST;
    busy = (op != emb_pkg::OP_IDLE);
    p.high_addr_port       = a[15:8];
    p.low_addr_data_port_o = a[7:0];
    p.ale = busy && in_win(c, emb_pkg::ALE_FIRST, emb_pkg::ALE_LAST);
    // address from period 0 gives one period before the latch rises
    if (busy && (c <= emb_pkg::ADDR_LAST)) begin
      p.low_addr_data_port_oe = 1'b1;
    end else if ((op == emb_pkg::OP_WRITE) &&
                 in_win(c, emb_pkg::WDATA_FIRST, emb_pkg::WDATA_LAST)) begin
      p.low_addr_data_port_o  = wd;
      p.low_addr_data_port_oe = 1'b1;
    end
    p.prog_store_strobe_n = !((op == emb_pkg::OP_FETCH) &&
                              in_win(c, emb_pkg::PROG_STORE_STROBE_N_FIRST, emb_pkg::PROG_STORE_STROBE_N_LAST));
    p.rd_strobe_n = !((op == emb_pkg::OP_READ) &&
                      in_win(c, emb_pkg::STRB_FIRST, emb_pkg::STRB_LAST));
    p.wr_strobe_n = !((op == emb_pkg::OP_WRITE) &&
                      in_win(c, emb_pkg::STRB_FIRST, emb_pkg::STRB_LAST));
    pins_for = p;
  endfunction

  // new requests are only taken at a cycle boundary so the address phase is whole
  assign at_end    = (st_ff.cnt == last_of(st_ff.op));
  assign req_ready = tick && at_end;

  always_comb begin
    nxt_st     = st_ff;
    nxt_st.rsp = 1'b0;
    // no tick, only the answer strobe drops: a stopped oscillator holds every pin and counter
    if (tick) begin
      if (at_end) begin
        nxt_st.cnt = '0;
        if (req_valid) begin
          nxt_st.op    = req.kind;
          nxt_st.addr  = req.addr;
          nxt_st.wdata = req.wdata;
        end else begin
          nxt_st.op = emb_pkg::OP_IDLE;
        end
      end else begin
        nxt_st.cnt = st_ff.cnt + 4'h1;
      end
      // capture in the last low period, before the strobe returns high
      if ((st_ff.op == emb_pkg::OP_FETCH) && (st_ff.cnt == emb_pkg::PROG_STORE_STROBE_N_LAST)) begin
        nxt_st.rdata = low_addr_data_port_i;
        nxt_st.rsp   = 1'b1;
      end
      if ((st_ff.op == emb_pkg::OP_READ) && (st_ff.cnt == emb_pkg::STRB_LAST)) begin
        nxt_st.rdata = low_addr_data_port_i;
        nxt_st.rsp   = 1'b1;
      end
      if ((st_ff.op == emb_pkg::OP_WRITE) && at_end) begin
        nxt_st.rsp = 1'b1;
      end
      if (st_ff.cnt == emb_pkg::PORT_SAMPLE) begin
        nxt_st.port_smp = gp_port_i;
      end
      if (st_ff.cnt == emb_pkg::PORT_UPDATE) begin
        nxt_st.port_out = gp_out_data;
      end
      nxt_st.pins = pins_for(nxt_st.op, nxt_st.cnt, nxt_st.addr, nxt_st.wdata);
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st_ff          <= '0;
      st_ff.op       <= emb_pkg::OP_IDLE;
      st_ff.cnt      <= emb_pkg::SHORT_LAST;
      st_ff.pins     <= emb_pkg::PINS_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rsp_valid             = st_ff.rsp;
  assign rsp_data              = st_ff.rdata;
  assign gp_in_data            = st_ff.port_smp;
  assign gp_port_o             = st_ff.port_out;
  assign low_addr_data_port_o  = st_ff.pins.low_addr_data_port_o;
  assign low_addr_data_port_oe = st_ff.pins.low_addr_data_port_oe;
  assign high_addr_port        = st_ff.pins.high_addr_port;
  assign ale                   = st_ff.pins.ale;
  assign prog_store_strobe_n   = st_ff.pins.prog_store_strobe_n;
  assign rd_strobe_n           = st_ff.pins.rd_strobe_n;
  assign wr_strobe_n           = st_ff.pins.wr_strobe_n;

endmodule

/* File: core/emb_pkg.sv */
package emb_pkg;

  // timing base: one oscillator period is one machine tick
  localparam int unsigned CLK_SYS_NS       = 40;
  localparam int unsigned OSC_MAX_MHZ      = 20;
  localparam int unsigned OSC_MIN_PHASE_NS = 25;
  // least number of clk_sys cycles each oscillator phase must last to be seen
  localparam int unsigned OSC_PHASE_CYC    =
    (OSC_MIN_PHASE_NS + CLK_SYS_NS - 1) / CLK_SYS_NS;

  localparam int unsigned CNT_W = 4;

  // tick positions inside one bus cycle, index 0 is the first period
  localparam logic [CNT_W-1:0] ALE_FIRST    = 4'h1;
  localparam logic [CNT_W-1:0] ALE_LAST     = 4'h2;
  localparam logic [CNT_W-1:0] ADDR_LAST    = 4'h3;
  localparam logic [CNT_W-1:0] PROG_STORE_STROBE_N_FIRST   = 4'h4;
  localparam logic [CNT_W-1:0] PROG_STORE_STROBE_N_LAST    = 4'h6;
  localparam logic [CNT_W-1:0] STRB_FIRST   = 4'h6;
  localparam logic [CNT_W-1:0] STRB_LAST    = 4'hb;
  localparam logic [CNT_W-1:0] WDATA_FIRST  = 4'h4;
  localparam logic [CNT_W-1:0] WDATA_LAST   = 4'hc;
  localparam logic [CNT_W-1:0] PORT_SAMPLE  = 4'h9;
  localparam logic [CNT_W-1:0] PORT_UPDATE  = 4'hb;
  localparam logic [CNT_W-1:0] SHORT_LAST   = 4'hb;
  localparam logic [CNT_W-1:0] LONG_LAST    = 4'hd;

  typedef enum logic [1:0] {
    OP_IDLE  = 2'h0,
    OP_FETCH = 2'h1,
    OP_READ  = 2'h3,
    OP_WRITE = 2'h2
  } emb_op_e;

  typedef struct packed {
    emb_op_e     kind;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } emb_req_s;

  typedef struct packed {
    logic       ale;
    logic       prog_store_strobe_n;
    logic       rd_strobe_n;
    logic       wr_strobe_n;
    logic [7:0] low_addr_data_port_o;
    logic       low_addr_data_port_oe;
    logic [7:0] high_addr_port;
  } emb_pins_s;

  localparam emb_pins_s PINS_RST = '{
    ale:                   1'b0,
    prog_store_strobe_n:   1'b1,
    rd_strobe_n:           1'b1,
    wr_strobe_n:           1'b1,
    low_addr_data_port_o:  8'h00,
    low_addr_data_port_oe: 1'b0,
    high_addr_port:        8'h00
  };

endpackage

/* File: core/emb_osc_tick.sv */
module emb_osc_tick (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  // oscillator level
  input  wire logic osc_input,
  // one clk_sys pulse per oscillator rising edge
  output logic      tick
);

  typedef struct packed {
    logic lvl_ff;
    logic tick_ff;
  } emb_tick_s;

  emb_tick_s st_ff;
  emb_tick_s nxt_st;

  // edge detect only: a stopped oscillator simply yields no ticks, any duty works
  always_comb begin
    nxt_st         = st_ff;
    nxt_st.lvl_ff  = osc_input;
    nxt_st.tick_ff = osc_input & ~st_ff.lvl_ff;
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign tick = st_ff.tick_ff;

endmodule

/* File: test/emb_bus_seq_checker.sv */
module emb_bus_seq_checker (
  // clock and reset
  input wire logic       clk_sys,
  input wire logic       sys_rst,
  // watched pins
  input wire logic       osc_input,
  input wire logic       ale,
  input wire logic       prog_store_strobe_n,
  input wire logic       rd_strobe_n,
  input wire logic       wr_strobe_n,
  input wire logic       low_addr_data_port_oe,
  input wire logic [7:0] low_addr_data_port_o,
  input wire logic [7:0] high_addr_port,
  input wire logic       rsp_valid
);
  timeunit 1ns;
  timeprecision 1ns;
  // mirror of the tick detector so that widths are counted in oscillator periods
  logic       osc_ff, upd_ff;
  logic [3:0] ale_ff, ps_ff, st_ff, since_ff;
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      {osc_ff, upd_ff, ale_ff, ps_ff, st_ff} <= '0;
      since_ff <= 4'hf;
    end else begin
      osc_ff <= osc_input;
      upd_ff <= osc_input & ~osc_ff;
      if (upd_ff) begin
        ale_ff   <= ale ? ale_ff + 4'h1 : 4'h0;
        ps_ff    <= prog_store_strobe_n ? 4'h0 : ps_ff + 4'h1;
        st_ff    <= (rd_strobe_n && wr_strobe_n) ? 4'h0 : st_ff + 4'h1;
        since_ff <= ale ? 4'h0 : (since_ff == 4'hf ? since_ff : since_ff + 4'h1);
      end
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  sequence bus_held;
    low_addr_data_port_oe && $stable(low_addr_data_port_o);
  endsequence
  sequence osc_still;
    $stable(osc_input) [*3];
  endsequence
  a_ale_width: assert property ($fell(ale) |-> ale_ff == 4'h2)
    else $error("latch strobe width wrong");
  a_addr_hold: assert property ($fell(ale) |-> bus_held ##1 bus_held)
    else $error("low address not held around latch fall");
  a_prog_store_strobe_n_delay: assert property ($fell(prog_store_strobe_n) |-> since_ff == 4'h1)
    else $error("program strobe fell at wrong period");
  a_prog_store_strobe_n_width: assert property ($rose(prog_store_strobe_n) |-> ps_ff == 4'h3 && rsp_valid)
    else $error("program strobe width or capture wrong");
  a_strobe_delay: assert property ($fell(rd_strobe_n) || $fell(wr_strobe_n) |-> since_ff == 4'h3)
    else $error("data strobe fell at wrong period");
  a_strobe_width: assert property ($rose(rd_strobe_n) || $rose(wr_strobe_n) |-> st_ff == 4'h6)
    else $error("data strobe width wrong");
  a_read_capture: assert property ($rose(rd_strobe_n) |-> rsp_valid)
    else $error("read data not captured at strobe end");
  a_wdata_setup: assert property ($fell(wr_strobe_n) |-> bus_held)
    else $error("write data not set up");
  a_wdata_hold: assert property ($rose(wr_strobe_n) |-> bus_held ##1 bus_held)
    else $error("write data not held");
  a_high_stable: assert property (!$stable(high_addr_port) |->
    !ale && prog_store_strobe_n && rd_strobe_n && wr_strobe_n)
    else $error("high address moved inside a cycle");
  a_stop_freeze: assert property (osc_still |-> $stable(ale) && $stable(high_addr_port))
    else $error("pins moved with oscillator stopped");
endmodule

bind emb_bus_seq emb_bus_seq_checker i_chk (.clk_sys, .sys_rst, .osc_input, .ale,
  .prog_store_strobe_n, .rd_strobe_n, .wr_strobe_n, .low_addr_data_port_oe,
  .low_addr_data_port_o, .high_addr_port, .rsp_valid);

/* File: test/emb_mem_model.sv */
module emb_mem_model (
  // bus pins seen from memory
  input wire logic       clk_sys,
  input wire logic       ale,
  input wire logic       prog_store_strobe_n,
  input wire logic       rd_strobe_n,
  input wire logic [7:0] low_addr_data_port_o,
  input wire logic [7:0] high_addr_port,
  // answer speed
  input wire logic       slow,
  // memory side of the data bus
  output logic [7:0]     mem_d
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] lo_q, val;
  logic [7:0] last_q = 8'h00;
  logic [4:0] age;
  logic       act;
  assign act = !prog_store_strobe_n || !rd_strobe_n;
  // program image is lo^hi, data image its inverse
  assign val = lo_q ^ high_addr_port ^ {8{prog_store_strobe_n}};
  always @(negedge ale) lo_q = low_addr_data_port_o;
  always_ff @(posedge clk_sys) begin
    age <= act ? age + 5'h1 : 5'h0;
    last_q <= mem_d;
  end
  // slow answers show garbage until the limit, taking four clk_sys per period
  always_comb begin
    if (!act) mem_d = ~last_q;
    else if (slow && age < (prog_store_strobe_n ? 5'd15 : 5'd7)) mem_d = {3'h0, age} ^ 8'h96;
    else mem_d = val;
  end
endmodule

/* File: test/testbench.sv */
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic              clk_sys = 1'b0, sys_rst = 1'b1, osc_input = 1'b0, osc_run = 1'b0;
  logic              req_valid = 1'b0, slow = 1'b0;
  emb_pkg::emb_req_s req = '0;
  logic [7:0]        gp_out_data = 8'h00, gp_port_i = 8'h00, mem_d, bus_i;
  logic [7:0]        rsp_data, gp_in_data, gp_port_o, lo_o, hi_o;
  logic              req_ready, rsp_valid, lo_oe, ale, psn, rdn, wrn;
  int                error_cnt = 0, compares = 0;
  assign bus_i = lo_oe ? lo_o : mem_d;
  initial forever #20 clk_sys = ~clk_sys;
  // oscillator of four clk_sys periods, stoppable in either level
  always begin
    repeat (2) @(negedge clk_sys);
    if (osc_run) osc_input <= ~osc_input;
  end
  emb_bus_seq i_dut (.clk_sys, .sys_rst, .osc_input, .req_valid, .req, .req_ready, .rsp_valid,
    .rsp_data, .gp_out_data, .gp_in_data, .gp_port_i, .gp_port_o, .low_addr_data_port_i(bus_i),
    .low_addr_data_port_o(lo_o), .low_addr_data_port_oe(lo_oe), .high_addr_port(hi_o), .ale,
    .prog_store_strobe_n(psn), .rd_strobe_n(rdn), .wr_strobe_n(wrn));
  emb_mem_model i_mem (.clk_sys, .ale, .prog_store_strobe_n(psn), .rd_strobe_n(rdn),
    .low_addr_data_port_o(lo_o), .high_addr_port(hi_o), .slow, .mem_d);
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic run_op(input emb_pkg::emb_op_e k, input logic [15:0] a, input logic [7:0] w);
    int n;
    @(negedge clk_sys);
    req_valid = 1'b1;
    req = '{kind: k, addr: a, wdata: w};
    n = 0;
    // ready is judged between edges, so the taking edge sees the request still standing
    while (req_ready !== 1'b1 && n < 400) begin
      @(negedge clk_sys);
      n++;
    end
    if (req_ready !== 1'b1) begin
      error_cnt++;
      $display("MISMATCH request accept expected 1 seen %b", req_ready);
    end
    @(posedge clk_sys);
    @(negedge clk_sys);
    req_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 400) begin
      @(negedge clk_sys);
      n++;
    end
    if (rsp_valid !== 1'b1) begin
      error_cnt++;
      $display("MISMATCH answer strobe expected 1 seen %b", rsp_valid);
    end
  endtask
  task automatic t_access;
    for (int s = 0; s < 4; s++) begin
      slow = s[1];
      run_op(s[0] ? emb_pkg::OP_READ : emb_pkg::OP_FETCH, 16'h80f1, 8'h00);
      chk("read data", {8'h00, s[0] ? 8'h8e : 8'h71}, {8'h00, rsp_data});
    end
  endtask
  task automatic t_write;
    fork
      run_op(emb_pkg::OP_WRITE, 16'h4455, 8'h3b);
      begin
        wait (wrn === 1'b0);
        @(negedge clk_sys);
        chk("write data", 16'h013b, {7'h0, lo_oe, lo_o});
        wait (wrn === 1'b1);
        @(negedge clk_sys);
        chk("write hold", 16'h013b, {7'h0, lo_oe, lo_o});
      end
    join
  endtask
  task automatic t_ports;
    gp_port_i = 8'h3c;
    gp_out_data = 8'ha7;
    // an idle cycle gives no answer, so two fetches make sure a whole cycle has passed
    run_op(emb_pkg::OP_FETCH, 16'h0000, 8'h00);
    run_op(emb_pkg::OP_FETCH, 16'h0000, 8'h00);
    chk("port sample", 16'h003c, {8'h00, gp_in_data});
    chk("port output", 16'h00a7, {8'h00, gp_port_o});
  endtask
  // a read is frozen once with the oscillator high and once low, then must still finish right
  task automatic t_stop;
    logic [11:0] snap;
    fork
      run_op(emb_pkg::OP_READ, 16'h12c4, 8'h00);
      for (int lv = 0; lv < 2; lv++) begin
        repeat (20) @(posedge clk_sys);
        while (osc_input !== lv[0]) @(posedge clk_sys);
        osc_run = 1'b0;
        // a tick already in flight may still move the pins once
        repeat (3) @(negedge clk_sys);
        snap = {ale, psn, rdn, wrn, hi_o};
        repeat (60) @(negedge clk_sys);
        chk("frozen pins", {4'h0, snap}, {4'h0, ale, psn, rdn, wrn, hi_o});
        osc_run = 1'b1;
      end
    join
    chk("read after stop", 16'h0029, {8'h00, rsp_data});
  endtask
  task automatic conclude;
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk_sys);
    @(negedge clk_sys);
    sys_rst = 1'b0;
    osc_run = 1'b1;
    t_access();
    t_write();
    t_ports();
    t_stop();
    conclude();
  end
  initial begin
    repeat (10000) @(posedge clk_sys);
    error_cnt++;
    conclude();
  end
endmodule
